// ### hw/relay_alarm_pkg.sv
// constants, types and helpers shared by the relay alarm design
package relay_alarm_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int N_CHAN = 8;
    localparam int CODE_W = 16;
    localparam int ADDR_W = 8;
    localparam logic [CODE_W-1:0] NULL_CODE = 16'h8000;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] CTRL_OFF = 8'h00;
    localparam logic [ADDR_W-1:0] STATUS_OFF = 8'h04;
    localparam logic [ADDR_W-1:0] WATER_LIM_OFF = 8'h08;
    localparam logic [ADDR_W-1:0] WATER_RES_OFF = 8'h0c;
    localparam logic [ADDR_W-1:0] LIMIT_BASE = 8'h20;
    localparam logic [ADDR_W-1:0] RESULT_BASE = 8'h40;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int MODE_LSB = 0;
    localparam int FORMAT_LSB = 4;
    localparam int LIM_LO_LSB = 0;
    localparam int LIM_UP_LSB = 16;
    localparam int ST_RELAY1 = 0;
    localparam int ST_RELAY2 = 1;
    localparam int ST_RUNNING = 2;
    localparam int ST_COMPLETE = 3;
    localparam int ST_HAVE_RES = 4;
    localparam int ST_HAVE_WATER = 5;
    localparam int ST_PART_LATCH = 6;
    localparam int ST_WATER_LATCH = 7;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [2:0] MODE_RST = 3'h0;
    localparam logic [2:0] FORMAT_RST = 3'h0;
    localparam logic [CODE_W-1:0] LIMIT_RST = 16'h0000;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_WARN_ALARM = 3'b000,
        MODE_CLEAN_DIRTY = 3'b001,
        MODE_TRAFFIC = 3'b010,
        MODE_PART_WATER = 3'b011,
        MODE_CONT_STOP = 3'b100,
        MODE_DONE_DIRTY = 3'b101,
        MODE_BUSY_DIRTY = 3'b110,
        MODE_CUSTOM = 3'b111
    } alarm_mode_t;

    typedef enum logic [2:0] {
        FMT_CODE3 = 3'b000,
        FMT_CLASS_A = 3'b001,
        FMT_CLASS_B = 3'b010,
        FMT_CLASS_C = 3'b011,
        FMT_CLASS_D = 3'b100
    } result_fmt_t;

    typedef enum logic [1:0] {
        TST_IDLE = 2'b00,
        TST_RUN = 2'b01,
        TST_DONE = 2'b10
    } test_state_t;

    // ------------------------------------------------------------
    // channels compared under a result format
    // ------------------------------------------------------------
    function automatic logic chan_used(input logic [2:0] fmt, input int idx);
        chan_used = (fmt == FMT_CODE3) ? 1'b1 : (idx == 0);
    endfunction

endpackage

// ### hw/cmp_if.sv
// one result channel against its lower and upper limits
`timescale 1ns/1ps
`default_nettype none
interface cmp_if;
    logic [15:0] value;
    logic [15:0] lower;
    logic [15:0] upper;
    logic enable;
    logic valid;
    logic gt_lo;
    logic gt_up;
    logic lt_up;
    modport cmp (input value, input lower, input upper, input enable,
                 output valid, output gt_lo, output gt_up, output lt_up);
    modport user (output value, output lower, output upper, output enable,
                  input valid, input gt_lo, input gt_up, input lt_up);
endinterface
`default_nettype wire

// ### hw/limit_compare.sv
// signed comparison of one result code with its two limits
`timescale 1ns/1ps
`default_nettype none
module limit_compare
    import relay_alarm_pkg::*;
(
    // channel
    cmp_if.cmp port
);
    logic signed [CODE_W-1:0] val_s;
    logic signed [CODE_W-1:0] lo_s;
    logic signed [CODE_W-1:0] up_s;

    assign val_s = port.value;
    assign lo_s = port.lower;
    assign up_s = port.upper;

    // null code means no result: the channel takes no part
    assign port.valid = port.enable && (port.value != NULL_CODE);
    // [RL17] signed codes of format
    assign port.gt_lo = port.valid && (val_s > lo_s);
    assign port.gt_up = port.valid && (val_s > up_s);
    assign port.lt_up = port.valid && (val_s < up_s);
endmodule
`default_nettype wire

// ### hw/hysteresis_latch.sv
// set above one threshold, clear at or below another, hold between
`timescale 1ns/1ps
`default_nettype none
module hysteresis_latch (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // conditions
    input wire logic set_i,
    input wire logic clr_i,
    // state
    output logic q_o
);
    logic q_q;
    logic q_d;

    // set wins when the lower limit is above the upper and both hold
    assign q_d = set_i ? 1'b1 : (clr_i ? 1'b0 : q_q);
    assign q_o = q_q;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q_q <= 1'b0;
        end else begin
            q_q <= q_d;
        end
    end
endmodule
`default_nettype wire

// ### hw/relay_alarm_mode_logic.sv
// two switched alarm outputs driven by result, limits, test state and mode
//
// Contract
// [RL1] mode 0: output 1 when any result above lower
// [RL2] mode 0: output 2 when any result above upper
// [RL3] mode 1: output 1 when result at/below lower
// [RL4] mode 1: output 2 when result above upper
// [RL5] mode 2: output 1 when result below upper
// [RL6] mode 2: output 2 when result above lower
// [RL7] mode 2: between limits both outputs on
// [RL8] mode 3: particle output with hysteresis
// [RL9] mode 3: water output with same hysteresis
// [RL10] single threshold: program equal limits
// [RL11] mode 4: above lower continue, else stop
// [RL12] mode 5: complete on 1, dirty on 2
// [RL13] controller starts, watches complete, samples dirty
// [RL14] mode 6: output 1 during test, dirty 2
// [RL15] no continuous testing in modes 5, 6
// [RL16] codes 7 up reserved, not decoded
// [RL17] compare in selected result format coding
// [RL18] reprogram limits after format change
// [RL19] mode drives only the two outputs
// [RL20] reserved mode holds both outputs off
`timescale 1ns/1ps
`default_nettype none
module relay_alarm_mode_logic
    import relay_alarm_pkg::*;
(
    // clock and reset
    input wire logic CORE_CLK_I,
    input wire logic RSTN_I,
    // apb slave
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [ADDR_W-1:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    // measurement engine
    input wire logic RESULT_VALID_I,
    input wire logic [N_CHAN*CODE_W-1:0] RESULT_I,
    input wire logic WATER_VALID_I,
    input wire logic [CODE_W-1:0] WATER_I,
    input wire logic TEST_START_I,
    input wire logic TEST_END_I,
    // switched outputs
    output logic RELAY1_O,
    output logic RELAY2_O
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [2:0] mode_q;
    logic [2:0] format_q;
    logic [CODE_W-1:0] lim_lo_q [N_CHAN];
    logic [CODE_W-1:0] lim_up_q [N_CHAN];
    logic [CODE_W-1:0] result_q [N_CHAN];
    logic [CODE_W-1:0] water_lo_q;
    logic [CODE_W-1:0] water_up_q;
    logic [CODE_W-1:0] water_q;
    test_state_t test_q;
    test_state_t test_d;
    logic relay1_q;
    logic relay1_d;
    logic relay2_q;
    logic relay2_d;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    logic setup_w;
    logic wr_en_w;
    logic aligned_w;
    logic hit_ctrl_w;
    logic hit_status_w;
    logic hit_wlim_w;
    logic hit_wres_w;
    logic hit_lim_w;
    logic hit_res_w;
    logic mapped_w;
    logic read_only_w;
    logic [2:0] idx_w;
    logic [31:0] status_w;
    logic [31:0] rd_data_w;

    assign setup_w = PSEL_I && !PENABLE_I;
    assign wr_en_w = PSEL_I && PENABLE_I && pready_q && PWRITE_I && !pslverr_q;
    assign aligned_w = (PADDR_I[1:0] == 2'b00);
    assign idx_w = PADDR_I[4:2];
    assign hit_ctrl_w = PADDR_I == CTRL_OFF;
    assign hit_status_w = PADDR_I == STATUS_OFF;
    assign hit_wlim_w = PADDR_I == WATER_LIM_OFF;
    assign hit_wres_w = PADDR_I == WATER_RES_OFF;
    assign hit_lim_w = aligned_w && (PADDR_I[7:5] == LIMIT_BASE[7:5]);
    assign hit_res_w = aligned_w && (PADDR_I[7:5] == RESULT_BASE[7:5]);
    assign mapped_w = hit_ctrl_w || hit_status_w || hit_wlim_w || hit_wres_w || hit_lim_w || hit_res_w;
    assign read_only_w = hit_status_w || hit_wres_w || hit_res_w;

    // ------------------------------------------------------------
    // comparators per particle channel and for water
    // ------------------------------------------------------------
    logic [N_CHAN-1:0] valid_w;
    logic [N_CHAN-1:0] gt_lo_w;
    logic [N_CHAN-1:0] gt_up_w;
    logic [N_CHAN-1:0] lt_up_w;

    genvar g;
    for (g = 0; g < N_CHAN; g++) begin : g_chan
        cmp_if chan_if ();
        assign chan_if.value = result_q[g];
        assign chan_if.lower = lim_lo_q[g];
        assign chan_if.upper = lim_up_q[g];
        // [RL17] format picks compared channels
        assign chan_if.enable = chan_used(format_q, g);
        limit_compare u_cmp (
            .port(chan_if.cmp)
        );
        assign valid_w[g] = chan_if.valid;
        assign gt_lo_w[g] = chan_if.gt_lo;
        assign gt_up_w[g] = chan_if.gt_up;
        assign lt_up_w[g] = chan_if.lt_up;
    end

    cmp_if water_if ();
    assign water_if.value = water_q;
    assign water_if.lower = water_lo_q;
    assign water_if.upper = water_up_q;
    assign water_if.enable = 1'b1;
    limit_compare u_water_cmp (
        .port(water_if.cmp)
    );

    // ------------------------------------------------------------
    // combined conditions
    // ------------------------------------------------------------
    logic have_res_w;
    logic any_gt_lo_w;
    logic any_gt_up_w;
    logic all_le_lo_w;
    logic all_lt_up_w;
    logic water_le_lo_w;
    logic part_alarm_w;
    logic water_alarm_w;

    // absent results never switch an output on
    assign have_res_w = |valid_w;
    assign any_gt_lo_w = |gt_lo_w;
    assign any_gt_up_w = |gt_up_w;
    assign all_le_lo_w = have_res_w && !any_gt_lo_w;
    assign all_lt_up_w = have_res_w && (&(lt_up_w | ~valid_w));
    assign water_le_lo_w = water_if.valid && !water_if.gt_lo;

    // [RL8] particle hysteresis
    hysteresis_latch u_part_latch (
        .clk_i(CORE_CLK_I),
        .rst_n_i(RSTN_I),
        .set_i(any_gt_up_w),
        .clr_i(all_le_lo_w),
        .q_o(part_alarm_w)
    );

    // [RL9] water hysteresis
    hysteresis_latch u_water_latch (
        .clk_i(CORE_CLK_I),
        .rst_n_i(RSTN_I),
        .set_i(water_if.gt_up),
        .clr_i(water_le_lo_w),
        .q_o(water_alarm_w)
    );

    // ------------------------------------------------------------
    // test state
    // ------------------------------------------------------------
    always_comb begin
        test_d = test_q;
        case (test_q)
            TST_IDLE: begin
                if (TEST_START_I) begin
                    test_d = TST_RUN;
                end
            end
            TST_RUN: begin
                if (TEST_END_I) begin
                    test_d = TST_DONE;
                end
            end
            TST_DONE: begin
                if (TEST_START_I) begin
                    test_d = TST_RUN;
                end
            end
            default: begin
                test_d = TST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // output selection by mode
    // ------------------------------------------------------------
    always_comb begin
        relay1_d = 1'b0;
        relay2_d = 1'b0;
        case (mode_q)
            MODE_WARN_ALARM: begin
                // [RL1] warning above lower
                relay1_d = any_gt_lo_w;
                // [RL2] alarm above upper
                relay2_d = any_gt_up_w;
            end
            MODE_CLEAN_DIRTY: begin
                // [RL3] clean at or below lower
                relay1_d = all_le_lo_w;
                // [RL4] dirty above upper
                relay2_d = any_gt_up_w;
            end
            MODE_TRAFFIC: begin
                // [RL5] green below upper
                relay1_d = all_lt_up_w;
                // [RL6] [RL7] red above lower, amber overlap
                relay2_d = any_gt_lo_w;
            end
            MODE_PART_WATER: begin
                // [RL8] particle latch on output 1
                relay1_d = part_alarm_w;
                // [RL9] water latch on output 2
                relay2_d = water_alarm_w;
            end
            MODE_CONT_STOP: begin
                // [RL11] continue or stop
                relay1_d = any_gt_lo_w;
                relay2_d = all_le_lo_w;
            end
            MODE_DONE_DIRTY: begin
                // [RL12] test complete, not clean
                relay1_d = (test_q == TST_DONE);
                relay2_d = any_gt_lo_w;
            end
            MODE_BUSY_DIRTY: begin
                // [RL14] testing, not clean
                relay1_d = (test_q == TST_RUN);
                relay2_d = any_gt_lo_w;
            end
            default: begin
                // [RL16] [RL20] reserved codes keep both off
                relay1_d = 1'b0;
                relay2_d = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    assign status_w = {24'h000000, water_alarm_w, part_alarm_w, water_if.valid, have_res_w,
                       test_q == TST_DONE, test_q == TST_RUN, relay2_q, relay1_q};
    assign rd_data_w = hit_ctrl_w ? {25'h0000000, format_q, 1'b0, mode_q} :
                       hit_status_w ? status_w :
                       hit_wlim_w ? {water_up_q, water_lo_q} :
                       hit_wres_w ? {16'h0000, water_q} :
                       hit_lim_w ? {lim_up_q[idx_w], lim_lo_q[idx_w]} :
                       hit_res_w ? {16'h0000, result_q[idx_w]} : 32'h00000000;

    // ------------------------------------------------------------
    // apb answer: no wait state, ready in the first access cycle, data and error fixed at setup
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end else begin
            pready_q <= setup_w;
            if (setup_w) begin
                pslverr_q <= !mapped_w || (PWRITE_I && read_only_w);
                prdata_q <= PWRITE_I ? 32'h00000000 : rd_data_w;
            end else if (pready_q) begin
                pslverr_q <= 1'b0;
                prdata_q <= 32'h00000000;
            end
        end
    end

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            mode_q <= MODE_RST;
            format_q <= FORMAT_RST;
            water_lo_q <= LIMIT_RST;
            water_up_q <= LIMIT_RST;
        end else if (wr_en_w && hit_ctrl_w) begin
            mode_q <= PWDATA_I[MODE_LSB +: 3];
            format_q <= PWDATA_I[FORMAT_LSB +: 3];
        end else if (wr_en_w && hit_wlim_w) begin
            water_lo_q <= PWDATA_I[LIM_LO_LSB +: CODE_W];
            water_up_q <= PWDATA_I[LIM_UP_LSB +: CODE_W];
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            for (int i = 0; i < N_CHAN; i++) begin
                lim_lo_q[i] <= LIMIT_RST;
                lim_up_q[i] <= LIMIT_RST;
            end
        end else if (wr_en_w && hit_lim_w) begin
            lim_lo_q[idx_w] <= PWDATA_I[LIM_LO_LSB +: CODE_W];
            lim_up_q[idx_w] <= PWDATA_I[LIM_UP_LSB +: CODE_W];
        end
    end

    // ------------------------------------------------------------
    // latest results
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            for (int i = 0; i < N_CHAN; i++) begin
                result_q[i] <= NULL_CODE;
            end
        end else if (RESULT_VALID_I) begin
            for (int i = 0; i < N_CHAN; i++) begin
                result_q[i] <= RESULT_I[i*CODE_W +: CODE_W];
            end
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            water_q <= NULL_CODE;
        end else if (WATER_VALID_I) begin
            water_q <= WATER_I;
        end
    end

    // ------------------------------------------------------------
    // test state and relay registers
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            test_q <= TST_IDLE;
            relay1_q <= 1'b0;
            relay2_q <= 1'b0;
        end else begin
            test_q <= test_d;
            // [RL19] mode reaches only these two
            relay1_q <= relay1_d;
            relay2_q <= relay2_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign PRDATA_O = prdata_q;
    assign PREADY_O = pready_q;
    assign PSLVERR_O = pslverr_q;
    assign RELAY1_O = relay1_q;
    assign RELAY2_O = relay2_q;

endmodule
`default_nettype wire

// ### dv/relay_plc_model.sv
// behavioural controller on the far side of the switched outputs
`timescale 1ns/1ps
`default_nettype none
module relay_plc_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // bench requests
    input wire logic go_i,
    input wire logic stop_i,
    // switched outputs
    input wire logic relay1_i,
    input wire logic relay2_i,
    // test control and verdict
    output logic start_o,
    output logic end_o,
    output logic fail_o
);
    logic r1_q;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            start_o <= 1'h0;
            end_o <= 1'h0;
            fail_o <= 1'h0;
            r1_q <= 1'h0;
        end else begin
            start_o <= go_i;
            end_o <= stop_i;
            r1_q <= relay1_i;
            if (relay1_i && !r1_q) begin
                fail_o <= relay2_i;
            end
        end
    end
endmodule
`default_nettype wire

// ### dv/relay_alarm_props.sv
// port assertions for the relay alarm block
`timescale 1ns/1ps
`default_nettype none
module relay_alarm_props
    import relay_alarm_pkg::*;
(
    // clock and reset
    input wire logic CORE_CLK_I,
    input wire logic RSTN_I,
    // apb
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [ADDR_W-1:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic PREADY_O,
    input wire logic PSLVERR_O,
    // test events and outputs
    input wire logic TEST_START_I,
    input wire logic TEST_END_I,
    input wire logic RELAY1_O,
    input wire logic RELAY2_O
);
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (!RSTN_I);
    logic [2:0] mode_q;
    logic [1:0] age_q;
    logic run_q;
    wire setup = PSEL_I && !PENABLE_I;
    wire ctrl_wr = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && PADDR_I == CTRL_OFF;
    wire settled = age_q == 2'h3;
    // mode, its age and the test state seen at the ports
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            mode_q <= MODE_RST;
            age_q <= 2'h0;
            run_q <= 1'h0;
        end else begin
            if (ctrl_wr) begin
                mode_q <= PWDATA_I[2:0];
            end
            age_q <= ctrl_wr ? 2'h0 : (settled ? age_q : age_q + 2'h1);
            if (TEST_START_I) begin
                run_q <= 1'h1;
            end else if (TEST_END_I) begin
                run_q <= 1'h0;
            end
        end
    end
    a_ready_next: assert property (setup |=> PREADY_O && PENABLE_I) else $error("no ready after setup");
    a_ready_pulse: assert property (PREADY_O |=> !PREADY_O) else $error("ready longer than one cycle");
    a_rdata_idle: assert property (!PREADY_O |-> PRDATA_O == 32'h0) else $error("read data outside access");
    a_err_unaligned: assert property (setup && PADDR_I[1:0] != 2'h0 |=> PSLVERR_O) else $error("unaligned not refused");
    a_reserved_off: assert property (
        mode_q == MODE_CUSTOM && settled |-> !RELAY1_O && !RELAY2_O) else $error("reserved mode output on");
    a_busy_on: assert property (
        mode_q == MODE_BUSY_DIRTY && settled && TEST_START_I |-> ##2 RELAY1_O) else $error("busy output late");
    a_busy_off: assert property (
        mode_q == MODE_BUSY_DIRTY && settled && TEST_END_I && run_q |-> ##2 !RELAY1_O) else $error("busy stuck");
    a_done_on: assert property (
        mode_q == MODE_DONE_DIRTY && settled && TEST_END_I && run_q |-> ##2 RELAY1_O) else $error("done late");
    a_done_off: assert property (
        mode_q == MODE_DONE_DIRTY && settled && TEST_START_I |-> ##2 !RELAY1_O) else $error("done stuck");
    a_stop_excl: assert property (
        mode_q == MODE_CONT_STOP && settled |-> !(RELAY1_O && RELAY2_O)) else $error("continue and stop both on");
    c_busy: cover property (mode_q == MODE_BUSY_DIRTY && RELAY1_O);
    c_refused: cover property (PSLVERR_O);
    c_both_latched: cover property (mode_q == MODE_PART_WATER && RELAY1_O && RELAY2_O);
endmodule
bind relay_alarm_mode_logic relay_alarm_props relay_alarm_props_i (.CORE_CLK_I(CORE_CLK_I), .RSTN_I(RSTN_I),
    .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
    .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .TEST_START_I(TEST_START_I),
    .TEST_END_I(TEST_END_I), .RELAY1_O(RELAY1_O), .RELAY2_O(RELAY2_O));
`default_nettype wire

// ### dv/tb_relay_alarm_mode_logic.sv
// self-checking bench for the relay alarm block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_count++; \
    $display("ERROR %0t: got %h exp %h", $time, (g), (e)); end end
module tb_relay_alarm_mode_logic
    import relay_alarm_pkg::*;
;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, rvalid = 1'h0, wvalid = 1'h0, go = 1'h0, stop = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, er, r1, r2, tstart, tend, fail;
    logic [127:0] res = {8{16'h8000}};
    logic [15:0] water = 16'h8000;
    int err_count = 0, checks_done = 0, cyc = 0;
    int modes[7] = '{0, 1, 2, 4, 5, 6, 7};
    int vals[5] = '{5, 10, 15, 20, 25};
    int hv[6] = '{5, 15, 25, 15, 10, 15};
    logic he[6] = '{0, 0, 1, 1, 0, 0};
    always #5 clk = ~clk;
    relay_alarm_mode_logic relay_alarm_mode_logic_i (.CORE_CLK_I(clk), .RSTN_I(rst_n), .PSEL_I(psel),
        .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .RESULT_VALID_I(rvalid), .RESULT_I(res),
        .WATER_VALID_I(wvalid), .WATER_I(water), .TEST_START_I(tstart), .TEST_END_I(tend),
        .RELAY1_O(r1), .RELAY2_O(r2));
    relay_plc_model relay_plc_model_i (.clk_i(clk), .rst_n_i(rst_n), .go_i(go), .stop_i(stop),
        .relay1_i(r1), .relay2_i(r2), .start_o(tstart), .end_o(tend), .fail_o(fail));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic end_sim();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        @(posedge clk);
        while (pready !== 1'h1) @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic ee);
        apb(1'h0, a, 32'h0);
        `CHK(rd, e)
        `CHK(er, ee)
    endtask
    task automatic feed(input logic [127:0] r, input logic [15:0] wv);
        @(posedge clk);
        res <= r;
        water <= wv;
        rvalid <= 1'h1;
        wvalid <= 1'h1;
        @(posedge clk);
        rvalid <= 1'h0;
        wvalid <= 1'h0;
        repeat (4) @(posedge clk);
    endtask
    task automatic kick(input logic s);
        @(posedge clk);
        go <= s;
        stop <= !s;
        @(posedge clk);
        go <= 1'h0;
        stop <= 1'h0;
        repeat (5) @(posedge clk);
    endtask
    function automatic logic [1:0] expv(input int m, input int v);
        case (m)
            0: expv = {v > 10, v > 20};
            1: expv = {v <= 10, v > 20};
            2: expv = {v < 20, v > 10};
            4: expv = {v > 10, v <= 10};
            5, 6: expv = {1'h0, v > 10};
            default: expv = 2'h0;
        endcase
    endfunction
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_count++;
            end_sim();
        end
    end
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'h1;
        rdchk(CTRL_OFF, 32'h0, 1'h0);
        rdchk(LIMIT_BASE, 32'h0, 1'h0);
        rdchk(8'h10, 32'h0, 1'h1);
        rdchk(8'h02, 32'h0, 1'h1);
        apb(1'h1, STATUS_OFF, 32'h3);
        `CHK(er, 1'h1)
        apb(1'h1, LIMIT_BASE, 32'h0014000a);
        apb(1'h1, WATER_LIM_OFF, 32'h0014000a);
        rdchk(LIMIT_BASE, 32'h0014000a, 1'h0);
        foreach (modes[i]) begin
            apb(1'h1, CTRL_OFF, modes[i]);
            foreach (vals[j]) begin
                feed({{7{NULL_CODE}}, vals[j][15:0]}, NULL_CODE);
                `CHK({r1, r2}, expv(modes[i], vals[j]))
            end
        end
        apb(1'h1, CTRL_OFF, 32'h3);
        foreach (hv[k]) begin
            feed({{7{NULL_CODE}}, hv[k][15:0]}, hv[k][15:0]);
            `CHK({r1, r2}, {2{he[k]}})
        end
        apb(1'h1, CTRL_OFF, 32'h6);
        feed({{7{NULL_CODE}}, 16'h000f}, NULL_CODE);
        kick(1'h1);
        `CHK({r1, r2}, 2'h3)
        kick(1'h0);
        `CHK({r1, r2}, 2'h1)
        apb(1'h1, CTRL_OFF, 32'h5);
        repeat (3) @(posedge clk);
        `CHK(r1, 1'h1)
        kick(1'h1);
        `CHK({r1, r2}, 2'h1)
        kick(1'h0);
        `CHK({r1, r2, fail}, 3'h7)
        apb(1'h1, CTRL_OFF, 32'h0);
        feed({{6{NULL_CODE}}, 16'h0019, 16'h0005}, NULL_CODE);
        `CHK({r1, r2}, 2'h3)
        apb(1'h1, CTRL_OFF, 32'h10);
        apb(1'h1, LIMIT_BASE, 32'h00140014);
        apb(1'h1, WATER_LIM_OFF, 32'h00140014);
        repeat (3) @(posedge clk);
        `CHK({r1, r2}, 2'h0)
        apb(1'h1, CTRL_OFF, 32'h13);
        feed({{7{NULL_CODE}}, 16'h0015}, 16'h0015);
        `CHK({r1, r2}, 2'h3)
        feed({{7{NULL_CODE}}, 16'h0014}, 16'h0014);
        `CHK({r1, r2}, 2'h0)
        rdchk(RESULT_BASE, 32'h00000014, 1'h0);
        rdchk(WATER_RES_OFF, 32'h00000014, 1'h0);
        end_sim();
    end
endmodule
`default_nettype wire
